// *** cic_pkg.sv ***
// package of constants for the cpu interrupt control block
package cic_pkg;

    // ************************************************************
    // widths and counts
    // ************************************************************
    localparam int unsigned CIC_DW         = 8;
    localparam int unsigned CIC_AW         = 4;
    localparam int unsigned CIC_PC_W       = 13;
    localparam int unsigned CIC_N_SRC      = 7;
    localparam int unsigned CIC_PF_A_W     = 3;
    localparam int unsigned CIC_PF_B_W     = 1;
    localparam int unsigned CIC_PORT_W     = 4;
    localparam int unsigned CIC_EVT_W      = 2;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [3:0] CIC_OFS_CTRL    = 4'h0;
    localparam logic [3:0] CIC_OFS_PFLAG_A = 4'h1;
    localparam logic [3:0] CIC_OFS_PFLAG_B = 4'h2;
    localparam logic [3:0] CIC_OFS_PEN_A   = 4'h3;
    localparam logic [3:0] CIC_OFS_PEN_B   = 4'h4;
    localparam logic [3:0] CIC_OFS_CFG     = 4'h5;
    localparam logic [3:0] CIC_OFS_EVT_ST  = 4'h6;
    localparam logic [3:0] CIC_OFS_EVT_MSK = 4'h7;

    // ************************************************************
    // irq_control_reg field positions
    // ************************************************************
    localparam int unsigned CIC_B_GIE      = 7;
    localparam int unsigned CIC_B_PEIE     = 6;
    localparam int unsigned CIC_B_T0_EN    = 5;
    localparam int unsigned CIC_B_EXT_EN   = 4;
    localparam int unsigned CIC_B_PCHG_EN  = 3;
    localparam int unsigned CIC_B_T0_FLG   = 2;
    localparam int unsigned CIC_B_EXT_FLG  = 1;
    localparam int unsigned CIC_B_PCHG_FLG = 0;

    // config and event status fields
    localparam int unsigned CIC_B_EDGE_RISE = 0;
    localparam int unsigned CIC_B_EV_VEC    = 0;
    localparam int unsigned CIC_B_EV_RET    = 1;

    // ************************************************************
    // reset values, vector and synchroniser depth
    // ************************************************************
    localparam logic [7:0]  CIC_CTRL_RST   = 8'h00;
    localparam logic [0:0]  CIC_CFG_RST    = 1'h1;
    localparam logic [12:0] CIC_IRQ_VECTOR = 13'h0004;
    localparam int unsigned CIC_SYNC_STAGES = 3;

endpackage

// *** cic_pin_if.sv ***
// interface carrying synchronised pin events from the pin stage to the controller
`timescale 1ns/10ps
`default_nettype none
interface cic_pin_if;
    logic ext_rise;
    logic ext_fall;
    logic port_chg;

    modport sync_mp (output ext_rise, output ext_fall, output port_chg);
    modport ctrl_mp (input ext_rise, input ext_fall, input port_chg);
endinterface
`default_nettype wire

// *** cic_pin_sync.sv ***
// three-stage pin synchroniser with stable-change detection
`timescale 1ns/10ps
`default_nettype none
module cic_pin_sync
    import cic_pkg::*;
#(
    parameter int unsigned PORT_W = CIC_PORT_W
) (
    input  wire logic              core_clk_i,     // core clock
    input  wire logic              rst_n_i,        // async reset, active low
    input  wire logic              ext_pin_i,      // external edge pin, raw
    input  wire logic [PORT_W-1:0] port_pins_i,    // port change pins, raw
    cic_pin_if.sync_mp             pin_evt         // events toward controller
);
    localparam int unsigned N = PORT_W + 1;

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
        logic [N-1:0] stable;
        logic         rise;
        logic         fall;
        logic         chg;
    } cic_sync_st_t;

    cic_sync_st_t st_ff;
    cic_sync_st_t nxt_st;
    logic [N-1:0] moved;
    logic [N-1:0] new_lvl;

    // ************************************************************
    // per pin change detection
    // ************************************************************
    // only stage two and three are compared; stage one feeds stage two alone
    for (genvar i = 0; i < N; i++) begin : g_pin
        assign moved[i]   = (st_ff.s2[i] == st_ff.s3[i]) && (st_ff.s3[i] != st_ff.stable[i]);
        assign new_lvl[i] = moved[i] ? st_ff.s3[i] : st_ff.stable[i];
    end

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.s1     = {port_pins_i, ext_pin_i};
        nxt_st.s2     = st_ff.s1;
        nxt_st.s3     = st_ff.s2;
        nxt_st.stable = new_lvl;
        nxt_st.rise   = moved[0] & new_lvl[0];
        nxt_st.fall   = moved[0] & ~new_lvl[0];
        nxt_st.chg    = |moved[N-1:1];
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pin_evt.ext_rise = st_ff.rise;
    assign pin_evt.ext_fall = st_ff.fall;
    assign pin_evt.port_chg = st_ff.chg;
endmodule
`default_nettype wire

// *** cic_irq_ctrl.sv ***
// cpu interrupt controller: flags, enables, global gate and vectoring
`timescale 1ns/10ps
`default_nettype none
module cic_irq_ctrl
    import cic_pkg::*;
#(
    parameter int unsigned PF_A_W = CIC_PF_A_W,
    parameter int unsigned PF_B_W = CIC_PF_B_W,
    parameter int unsigned PORT_W = CIC_PORT_W
) (
    input  wire logic                core_clk_i,                 // core clock
    input  wire logic                rst_n_i,                    // async reset, active low
    input  wire logic [CIC_AW-1:0]   reg_addr_i,                 // register address
    input  wire logic [CIC_DW-1:0]   reg_wdata_i,                // register write data
    input  wire logic                reg_wr_i,                   // write strobe
    input  wire logic                reg_rd_i,                   // read strobe
    output logic      [CIC_DW-1:0]   reg_rdata_o,                // read data, cycle after strobe
    input  wire logic                external_edge_irq_pin_i,    // external edge pin
    input  wire logic [PORT_W-1:0]   port_b_change_pins_i,       // port change pins
    input  wire logic                timer_zero_ovf_i,           // timer zero overflow pulse
    input  wire logic [PF_A_W-1:0]   periph_evt_a_i,             // peripheral events, group a
    input  wire logic [PF_B_W-1:0]   periph_evt_b_i,             // peripheral events, group b
    input  wire logic                icyc_end_i,                 // last clock of instr cycle
    input  wire logic                return_from_irq_instr_i,    // return instruction executed
    input  wire logic [CIC_PC_W-1:0] cur_pc_i,                   // return address from core
    output logic                     irq_inject_o,               // force no-op cycle in core
    output logic                     stack_push_o,               // push return address
    output logic      [CIC_PC_W-1:0] stack_push_data_o,          // address to push
    output logic                     program_counter_load_o,     // load program counter
    output logic      [CIC_PC_W-1:0] program_counter_o,          // value to load
    output logic                     sys_irq_o                   // system interrupt, level
);

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HOLD
    } cic_seq_t;

    typedef struct packed {
        logic [CIC_DW-1:0]    ctrl;
        logic [PF_A_W-1:0]    pflag_a;
        logic [PF_B_W-1:0]    pflag_b;
        logic [PF_A_W-1:0]    pen_a;
        logic [PF_B_W-1:0]    pen_b;
        logic                 edge_rise;
        logic [CIC_EVT_W-1:0] evt_st;
        logic [CIC_EVT_W-1:0] evt_msk;
        logic [CIC_DW-1:0]    rdata;
        cic_seq_t             seq;
        logic                 inject;
        logic                 push;
        logic                 load;
        logic [CIC_PC_W-1:0]  push_data;
        logic [CIC_PC_W-1:0]  pc_val;
    } cic_state_t;

    cic_state_t st_ff;
    cic_state_t nxt_st;

    cic_pin_if pin_evt ();

    logic                 ext_evt;
    logic [2:0]           core_set;
    logic [2:0]           core_flg;
    logic [2:0]           core_en;
    logic                 core_req;
    logic                 periph_req;
    logic                 take;
    logic                 wr_ctrl;
    logic [CIC_EVT_W-1:0] evt_set;

    // ************************************************************
    // pin synchroniser
    // ************************************************************
    cic_pin_sync #(
        .PORT_W      (PORT_W)
    ) u_pin_sync (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .ext_pin_i   (external_edge_irq_pin_i),
        .port_pins_i (port_b_change_pins_i),
        .pin_evt     (pin_evt)
    );

    // ************************************************************
    // request logic
    // ************************************************************
    assign ext_evt  = st_ff.edge_rise ? pin_evt.ext_rise : pin_evt.ext_fall;

    assign core_set = {timer_zero_ovf_i, ext_evt, pin_evt.port_chg};

    // core flags and enables in control reg
    assign core_flg = {st_ff.ctrl[CIC_B_T0_FLG], st_ff.ctrl[CIC_B_EXT_FLG],
                       st_ff.ctrl[CIC_B_PCHG_FLG]};
    assign core_en  = {st_ff.ctrl[CIC_B_T0_EN], st_ff.ctrl[CIC_B_EXT_EN],
                       st_ff.ctrl[CIC_B_PCHG_EN]};

    assign core_req = |(core_flg & core_en);

    assign periph_req = st_ff.ctrl[CIC_B_PEIE] &
                        ((|(st_ff.pflag_a & st_ff.pen_a)) | (|(st_ff.pflag_b & st_ff.pen_b)));

    // no further condition than enable and request
    assign take = st_ff.ctrl[CIC_B_GIE] & (core_req | periph_req);

    assign wr_ctrl = reg_wr_i && (reg_addr_i == CIC_OFS_CTRL);

    assign evt_set[CIC_B_EV_VEC] = (st_ff.seq == ST_HOLD) && icyc_end_i;
    assign evt_set[CIC_B_EV_RET] = return_from_irq_instr_i;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.push   = 1'b0;
        nxt_st.load   = 1'b0;
        nxt_st.rdata  = '0;

        // software writes; hardware sets below win over clears
        if (wr_ctrl) begin
            nxt_st.ctrl = reg_wdata_i;
        end
        if (reg_wr_i && (reg_addr_i == CIC_OFS_PFLAG_A)) begin
            nxt_st.pflag_a = reg_wdata_i[PF_A_W-1:0];
        end
        if (reg_wr_i && (reg_addr_i == CIC_OFS_PFLAG_B)) begin
            nxt_st.pflag_b = reg_wdata_i[PF_B_W-1:0];
        end
        if (reg_wr_i && (reg_addr_i == CIC_OFS_PEN_A)) begin
            nxt_st.pen_a = reg_wdata_i[PF_A_W-1:0];
        end
        if (reg_wr_i && (reg_addr_i == CIC_OFS_PEN_B)) begin
            nxt_st.pen_b = reg_wdata_i[PF_B_W-1:0];
        end
        if (reg_wr_i && (reg_addr_i == CIC_OFS_CFG)) begin
            nxt_st.edge_rise = reg_wdata_i[CIC_B_EDGE_RISE];
        end
        if (reg_wr_i && (reg_addr_i == CIC_OFS_EVT_MSK)) begin
            nxt_st.evt_msk = reg_wdata_i[CIC_EVT_W-1:0];
        end

        // seven flag bits set by their events
        // events only ever set, software clears
        nxt_st.ctrl[CIC_B_T0_FLG]   = nxt_st.ctrl[CIC_B_T0_FLG]   | core_set[2];
        nxt_st.ctrl[CIC_B_EXT_FLG]  = nxt_st.ctrl[CIC_B_EXT_FLG]  | core_set[1];
        nxt_st.ctrl[CIC_B_PCHG_FLG] = nxt_st.ctrl[CIC_B_PCHG_FLG] | core_set[0];
        nxt_st.pflag_a              = nxt_st.pflag_a | periph_evt_a_i;
        nxt_st.pflag_b              = nxt_st.pflag_b | periph_evt_b_i;

        // fixed two-boundary path, same for one or two cycle instructions
        case (st_ff.seq)
            ST_IDLE: begin
                if (icyc_end_i && take) begin
                    nxt_st.seq    = ST_HOLD;
                    nxt_st.inject = 1'b1;
                end
            end
            ST_HOLD: begin
                if (icyc_end_i) begin
                    nxt_st.ctrl[CIC_B_GIE] = 1'b0;
                    nxt_st.push            = 1'b1;
                    nxt_st.push_data       = cur_pc_i;
                    nxt_st.load            = 1'b1;
                    nxt_st.pc_val          = CIC_IRQ_VECTOR;
                    nxt_st.inject          = 1'b0;
                    nxt_st.seq             = ST_IDLE;
                end
            end
            default: begin
                nxt_st.seq    = ST_IDLE;
                nxt_st.inject = 1'b0;
            end
        endcase

        // return instruction re-enables, wins over a write
        if (return_from_irq_instr_i) begin
            nxt_st.ctrl[CIC_B_GIE] = 1'b1;
        end

        // register reads, one cycle latency, zero otherwise
        if (reg_rd_i) begin
            case (reg_addr_i)
                CIC_OFS_CTRL:    nxt_st.rdata = st_ff.ctrl;
                CIC_OFS_PFLAG_A: nxt_st.rdata = CIC_DW'(st_ff.pflag_a);
                CIC_OFS_PFLAG_B: nxt_st.rdata = CIC_DW'(st_ff.pflag_b);
                CIC_OFS_PEN_A:   nxt_st.rdata = CIC_DW'(st_ff.pen_a);
                CIC_OFS_PEN_B:   nxt_st.rdata = CIC_DW'(st_ff.pen_b);
                CIC_OFS_CFG:     nxt_st.rdata = CIC_DW'(st_ff.edge_rise);
                CIC_OFS_EVT_ST:  nxt_st.rdata = CIC_DW'(st_ff.evt_st);
                CIC_OFS_EVT_MSK: nxt_st.rdata = CIC_DW'(st_ff.evt_msk);
                default:         nxt_st.rdata = '0;
            endcase
        end

        // sticky event status: read clears, a same-cycle event survives
        if (reg_rd_i && (reg_addr_i == CIC_OFS_EVT_ST)) begin
            nxt_st.evt_st = '0;
        end
        nxt_st.evt_st = nxt_st.evt_st | evt_set;
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff           <= '0;
            st_ff.ctrl      <= CIC_CTRL_RST;
            st_ff.edge_rise <= CIC_CFG_RST;
            st_ff.seq       <= ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // flags are left to software polling; nothing clears them here
    assign reg_rdata_o            = st_ff.rdata;
    assign irq_inject_o           = st_ff.inject;
    assign stack_push_o           = st_ff.push;
    assign stack_push_data_o      = st_ff.push_data;
    assign program_counter_load_o = st_ff.load;
    assign program_counter_o      = st_ff.pc_val;
    assign sys_irq_o              = |(st_ff.evt_st & st_ff.evt_msk);

endmodule
`default_nettype wire

// *** cic_irq_ctrl_asserts.sv ***
// port-level assertion checker for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module cic_irq_ctrl_chk
    import cic_pkg::*;
(
    input wire logic                core_clk_i,              // clock
    input wire logic                rst_n_i,                 // reset
    input wire logic [CIC_AW-1:0]   reg_addr_i,              // address
    input wire logic [CIC_DW-1:0]   reg_wdata_i,             // wdata
    input wire logic                reg_wr_i,                // write
    input wire logic                reg_rd_i,                // read
    input wire logic [CIC_DW-1:0]   reg_rdata_o,             // rdata
    input wire logic                return_from_irq_instr_i, // return
    input wire logic                icyc_end_i,              // boundary
    input wire logic [CIC_PC_W-1:0] cur_pc_i,                // core pc
    input wire logic                irq_inject_o,            // no-op
    input wire logic                stack_push_o,            // push
    input wire logic [CIC_PC_W-1:0] stack_push_data_o,       // pushed
    input wire logic                program_counter_load_o,  // load
    input wire logic [CIC_PC_W-1:0] program_counter_o,       // vector
    input wire logic                sys_irq_o                // irq level
);
    // ************************************************************
    // shadow of the global enable
    // ************************************************************
    logic gie_sh_ff;

    // return beats vector, vector beats a control write in the same cycle
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gie_sh_ff <= 1'b0;
        end else if (return_from_irq_instr_i) begin
            gie_sh_ff <= 1'b1;
        end else if (irq_inject_o && icyc_end_i) begin
            gie_sh_ff <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == CIC_OFS_CTRL) begin
            gie_sh_ff <= reg_wdata_i[CIC_B_GIE];
        end
    end

    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    gie_gates_take_a: assert property (
        $rose(irq_inject_o) |-> $past(gie_sh_ff) && $past(icyc_end_i))
        else $error("take without global enable or off boundary");
    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
        else $error("read data outside its slot");
    unmapped_zero_a: assert property (
        $past(reg_rd_i) && $past(reg_addr_i) > 4'h7 |-> reg_rdata_o == '0)
        else $error("unmapped read not zero");
    vector_pair_a: assert property (
        stack_push_o || program_counter_load_o |-> stack_push_o
        && program_counter_load_o && program_counter_o == CIC_IRQ_VECTOR)
        else $error("push and vector load apart or wrong vector");
    push_after_noop_a: assert property (
        stack_push_o |-> $past(irq_inject_o) && $past(icyc_end_i) && !irq_inject_o)
        else $error("push not after no-op boundary");
    push_ret_addr_a: assert property (
        stack_push_o |-> stack_push_data_o == $past(cur_pc_i))
        else $error("pushed address differs from core pc");
    push_single_a: assert property (stack_push_o |=> !stack_push_o)
        else $error("push longer than one cycle");
    noop_stands_a: assert property (
        irq_inject_o && !icyc_end_i |=> irq_inject_o)
        else $error("no-op dropped before boundary");
    noop_ends_a: assert property (irq_inject_o && icyc_end_i |=> !irq_inject_o)
        else $error("no-op held past vector boundary");
    irq_rise_cause_a: assert property (
        $rose(sys_irq_o) |-> stack_push_o || $past(return_from_irq_instr_i)
        || $past(reg_wr_i))
        else $error("status interrupt without event");
    irq_fall_cause_a: assert property (
        $fell(sys_irq_o) |-> $past(reg_rd_i) || $past(reg_wr_i))
        else $error("status interrupt dropped by itself");

    cover property (stack_push_o);
    cover property ($past(reg_rd_i) && $past(reg_addr_i) > 4'h7);
    cover property ($rose(sys_irq_o) && $past(return_from_irq_instr_i));
endmodule
`default_nettype wire

// *** cic_core_model.sv ***
// behavioural core sequencer: instruction boundaries and program counter
`timescale 1ns/10ps
`default_nettype none
module cic_core_model
    import cic_pkg::*;
(
    input  wire logic                core_clk_i, // clock
    input  wire logic                rst_n_i,    // reset
    input  wire logic                inject_i,   // forced no-op
    input  wire logic                pc_load_i,  // vector load
    input  wire logic [CIC_PC_W-1:0] pc_vec_i,   // vector value
    output logic                     icyc_end_o, // last clock of cycle
    output logic      [CIC_PC_W-1:0] pc_o        // current pc
);
    logic [1:0]          phase_ff;
    logic [CIC_PC_W-1:0] pc_ff;

    // four clocks per instruction cycle
    assign icyc_end_o = (phase_ff == 2'h3);
    assign pc_o       = pc_ff;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_ff <= 2'h0;
            pc_ff    <= 13'h0000;
        end else begin
            phase_ff <= phase_ff + 2'h1;
            if (pc_load_i) begin
                pc_ff <= pc_vec_i;
            end else if (icyc_end_o && !inject_i) begin
                pc_ff <= pc_ff + 13'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// *** cic_irq_ctrl_tb.sv ***
// self-checking testbench for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module cic_irq_ctrl_tb
    import cic_pkg::*;
;
    logic        clk, rst_n, wr, rd, ext, t0, icyc, ret, inj, push, ld, irq;
    logic [3:0]  addr, port;
    logic [7:0]  wdata, rdata;
    logic [2:0]  pa;
    logic [0:0]  pb;
    logic [12:0] cpc, pdat, pcv;
    int          n_mismatch, n_checks, n_cyc, n;
    logic [7:0]  tbl_pen [4] = '{8'h02, 8'h01, 8'h01, 8'h01};
    logic [7:0]  tbl_ctl [4] = '{8'hc0, 8'h40, 8'h80, 8'hc0};

    cic_irq_ctrl DUT (
        .core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .external_edge_irq_pin_i(ext), .port_b_change_pins_i(port),
        .timer_zero_ovf_i(t0), .periph_evt_a_i(pa), .periph_evt_b_i(pb),
        .icyc_end_i(icyc), .return_from_irq_instr_i(ret), .cur_pc_i(cpc),
        .irq_inject_o(inj), .stack_push_o(push), .stack_push_data_o(pdat),
        .program_counter_load_o(ld), .program_counter_o(pcv), .sys_irq_o(irq));
    cic_core_model u_core (.core_clk_i(clk), .rst_n_i(rst_n), .inject_i(inj),
        .pc_load_i(ld), .pc_vec_i(pcv), .icyc_end_o(icyc), .pc_o(cpc));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(16'(rdata), 16'(exp));
    endtask
    // bounded wait; 40 means no vector came
    task automatic wait_push(output int cnt);
        cnt = 0;
        while (push !== 1'b1 && cnt < 40) begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // run should need well under a thousand cycles
    always @(posedge clk) begin
        n_cyc++;
        if (n_cyc == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {rst_n, wr, rd, ext, t0, ret, addr, port, wdata, pa, pb} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(CIC_OFS_CTRL, 8'h00);
        rd_reg(CIC_OFS_CFG, 8'h01);
        rd_reg(4'h9, 8'h00);
        @(posedge clk);
        t0   <= 1'b1;
        pa   <= 3'h5;
        pb   <= 1'h1;
        @(posedge clk);
        t0   <= 1'b0;
        pa   <= 3'h0;
        pb   <= 1'h0;
        port <= 4'h2;
        ext  <= 1'b1;
        repeat (8) @(posedge clk);
        rd_reg(CIC_OFS_CTRL, 8'h07);
        rd_reg(CIC_OFS_PFLAG_A, 8'h05);
        rd_reg(CIC_OFS_PFLAG_B, 8'h01);
        rd_reg(CIC_OFS_CTRL, 8'h07);
        wr_reg(CIC_OFS_EVT_MSK, 8'h03);
        for (int i = 0; i < 4; i++) begin
            wr_reg(CIC_OFS_CTRL, 8'h00);
            wr_reg(CIC_OFS_PEN_A, tbl_pen[i]);
            wr_reg(CIC_OFS_CTRL, tbl_ctl[i]);
            wait_push(n);
            chk(16'(n < 40), 16'(i == 3));
        end
        chk(16'(pcv), 16'(CIC_IRQ_VECTOR));
        chk(16'(pdat), 16'(cpc));
        chk(16'(irq), 16'h1);
        rd_reg(CIC_OFS_CTRL, 8'h40);
        rd_reg(CIC_OFS_EVT_ST, 8'h01);
        chk(16'(irq), 16'h0);
        // service: clear the flag, then return
        wr_reg(CIC_OFS_PFLAG_A, 8'h00);
        @(posedge clk);
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        rd_reg(CIC_OFS_CTRL, 8'hc0);
        wait_push(n);
        chk(16'(n), 16'd40);
        rd_reg(CIC_OFS_EVT_ST, 8'h02);
        // edge pin latency, falling edge ignored
        ext <= 1'b0;
        wr_reg(CIC_OFS_PEN_A, 8'h00);
        wr_reg(CIC_OFS_CTRL, 8'h90);
        repeat (8) @(posedge clk);
        chk(16'(push), 16'h0);
        rd_reg(CIC_OFS_CTRL, 8'h90);
        @(posedge clk);
        ext <= 1'b1;
        wait_push(n);
        chk(16'(n >= 8 && n <= 16), 16'h1);
        rd_reg(CIC_OFS_CTRL, 8'h12);
        // falling edge mode: only a fall may flag the pin
        wr_reg(CIC_OFS_CFG, 8'h00);
        wr_reg(CIC_OFS_CTRL, 8'h90);
        ext <= 1'b0;
        wait_push(n);
        chk(16'(n >= 8 && n <= 16), 16'h1);
        rd_reg(CIC_OFS_CTRL, 8'h12);
        rd_reg(CIC_OFS_CFG, 8'h00);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(CIC_OFS_CTRL, 8'h00);
        rd_reg(CIC_OFS_CFG, 8'h01);
        wrap_up();
    end
endmodule

bind cic_irq_ctrl cic_irq_ctrl_chk u_chk (
    .core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .return_from_irq_instr_i, .icyc_end_i, .cur_pc_i,
    .irq_inject_o, .stack_push_o, .stack_push_data_o, .program_counter_load_o,
    .program_counter_o, .sys_irq_o);
`default_nettype wire
